/* rtl/tx_channel_ctl.sv */
// How it works
// [R01] line tristate bit floats the line outputs and freezes monitor status; set at reset
// [R02] a detected short floats the analog output only, unless auto-tristate disable is set
// [R03] pulse source select chooses mask registers (0) or extended pulse registers (1)
// [R04] line control keeps fourth-level bits 3..0 in bits 3..0; bit 7 reads zero
// [R05] edge choices act only while edge select enable is set
// [R06] enabled receive edge bit picks the opposite edge for the receive sync pulse
// [R07] enabled transmit edge bit picks the opposite edge for the transmit sync pulse
// [R08] with channel loop-back, a looped slot is replaced by the idle code
// [R09] slot bytes, idle code included, go out most significant bit first
// [R10] at multiframe start with link access: interrupt, shadow copy, send unless transparent
// [R11] link bits start at bit 0 of register 1; 2, 12 or 24 bits by format
// [R12] unchanged link registers are simply sent again next multiframe
// [R13] clear-channel bit low lets robbing and zero suppression alter the slot
// [R14] clear-channel bit high keeps robbing and zero suppression off the slot
// [R15] clear-channel bits: channel 1 at bit 7 of register 1 down to 24
// [R16] idle-slot bit set overwrites that timeslot with the idle code
// [R17] idle-slot bits: slot 1 at bit 7 of register 1 down to slot 24
// [R18] all registers are 8 bits, read back as written, fixed bits zero; here interrupt clear reads zero, interrupt and line status ignore writes
//
// Local design decision: the AXI4-Lite interface to the registers.
module tx_channel_ctl (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire tx_ctl_pkg::slot_in_s slot_in,
   input  wire logic                 bit_tick,
   input  wire logic                 tx_multiframe_begin,
   input  wire logic                 dl_bit_req,
   input  wire logic                 short_detect,
   output tx_ctl_pkg::dl_out_s       dl_out,
   output logic                      line_bit,
   output logic                      analog_tx_out_oe,
   output logic                      digital_tx_oe,
   output logic                      pulse_source_select,
   output logic [3:0]                fourth_level_hi,
   output logic                      rx_sync_opposite,
   output logic                      tx_sync_opposite,
   output logic                      irq
);

   typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_state_e;
   typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_e;

   wr_state_e   wr_state, next_wr_state;
   rd_state_e   rd_state, next_rd_state;
   logic [1:0]  bresp, next_bresp;
   logic [31:0] rdata, next_rdata;
   logic [1:0]  rresp, next_rresp;

   logic [7:0]  line_ctl, next_line_ctl;
   logic [7:0]  sync_edge, next_sync_edge;
   logic [7:0]  idle_code, next_idle_code;
   logic [7:0]  dl_reg [3], next_dl_reg [3];
   logic [7:0]  cc_reg [3], next_cc_reg [3];
   logic [7:0]  ic_reg [3], next_ic_reg [3];
   logic [7:0]  mode_ctl, next_mode_ctl;
   logic [7:0]  irq_en, next_irq_en;
   logic [7:0]  irq_stat, next_irq_stat;
   logic        monitor_short, next_monitor_short;

   logic [23:0] dl_shadow, next_dl_shadow;
   logic [4:0]  dl_ptr, next_dl_ptr;
   logic [4:0]  dl_len, next_dl_len;
   logic        dl_send, next_dl_send;
   tx_ctl_pkg::dl_out_s next_dl_out;

   logic [7:0]  shift, next_shift;
   logic [2:0]  bit_cnt, next_bit_cnt;
   logic        next_line_bit;

   logic        wr_fire, rd_fire;
   logic [7:0]  wr_idx, rd_idx, wbyte;
   logic [23:0] cc_vec, ic_vec;
   logic [7:0]  slot_byte;
   logic        mf_event;

   // word-aligned address to register index; low bits ignored
   function automatic logic [7:0] to_index(input logic [11:0] addr);
      return addr[9:2];
   endfunction : to_index

   // pick the flag of a slot; slot 1 sits in the top bit
   function automatic logic slot_flag(input logic [23:0] vec, input logic [4:0] idx);
      return vec[tx_ctl_pkg::LAST_SLOT - idx];
   endfunction : slot_flag

   // is an index one of the readable registers
   function automatic logic mapped(input logic [7:0] idx);
      return (idx >= tx_ctl_pkg::IDX_LINE_CTL && idx <= tx_ctl_pkg::IDX_IC_3
              && idx != 8'h29) || (idx >= tx_ctl_pkg::IDX_MODE_CTL
              && idx <= tx_ctl_pkg::IDX_LINE_STAT);
   endfunction : mapped

   assign cc_vec = {cc_reg[0], cc_reg[1], cc_reg[2]}; // R15
   assign ic_vec = {ic_reg[0], ic_reg[1], ic_reg[2]}; // R17
   assign wr_idx = to_index(s_axi_awaddr);
   assign rd_idx = to_index(s_axi_araddr);
   assign wbyte  = s_axi_wdata[7:0];

   // both write channels are taken together, only when idle
   assign s_axi_awready = (wr_state == W_IDLE) && s_axi_awvalid && s_axi_wvalid;
   assign s_axi_wready  = s_axi_awready;
   assign wr_fire       = s_axi_awready;
   assign s_axi_arready = (rd_state == R_IDLE);
   assign rd_fire       = s_axi_arready && s_axi_arvalid;
   assign s_axi_bvalid  = (wr_state == W_RESP);
   assign s_axi_bresp   = bresp;
   assign s_axi_rvalid  = (rd_state == R_DATA);
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;
   assign mf_event      = tx_multiframe_begin && mode_ctl[tx_ctl_pkg::MC_DL_ACCESS];

   // bus handshake state
   always_comb begin
      next_wr_state = wr_state;
      next_bresp    = bresp;
      next_rd_state = rd_state;
      next_rdata    = rdata;
      next_rresp    = rresp;
      unique case (wr_state)
         W_IDLE: begin
            if (wr_fire) begin
               next_wr_state = W_RESP;
               next_bresp    = mapped(wr_idx) ? tx_ctl_pkg::RESP_OKAY
                                              : tx_ctl_pkg::RESP_SLVERR;
            end
         end
         W_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = W_IDLE;
            end
         end
         default: next_wr_state = W_IDLE;
      endcase
      unique case (rd_state)
         R_IDLE: begin
            if (rd_fire) begin
               next_rd_state = R_DATA;
               next_rresp    = mapped(rd_idx) ? tx_ctl_pkg::RESP_OKAY
                                              : tx_ctl_pkg::RESP_SLVERR;
               next_rdata    = 32'h0000_0000;
               unique case (rd_idx) // R18
                  tx_ctl_pkg::IDX_LINE_CTL:   next_rdata[7:0] = line_ctl;
                  tx_ctl_pkg::IDX_SYNC_EDGE:  next_rdata[7:0] = sync_edge;
                  tx_ctl_pkg::IDX_IDLE_CODE:  next_rdata[7:0] = idle_code;
                  tx_ctl_pkg::IDX_DL_1:       next_rdata[7:0] = dl_reg[0];
                  tx_ctl_pkg::IDX_DL_2:       next_rdata[7:0] = dl_reg[1];
                  tx_ctl_pkg::IDX_DL_3:       next_rdata[7:0] = dl_reg[2];
                  tx_ctl_pkg::IDX_CC_1:       next_rdata[7:0] = cc_reg[0];
                  tx_ctl_pkg::IDX_CC_2:       next_rdata[7:0] = cc_reg[1];
                  tx_ctl_pkg::IDX_CC_3:       next_rdata[7:0] = cc_reg[2];
                  tx_ctl_pkg::IDX_IC_1:       next_rdata[7:0] = ic_reg[0];
                  tx_ctl_pkg::IDX_IC_2:       next_rdata[7:0] = ic_reg[1];
                  tx_ctl_pkg::IDX_IC_3:       next_rdata[7:0] = ic_reg[2];
                  tx_ctl_pkg::IDX_MODE_CTL:   next_rdata[7:0] = mode_ctl;
                  tx_ctl_pkg::IDX_IRQ_STATUS: next_rdata[7:0] = irq_stat;
                  tx_ctl_pkg::IDX_IRQ_ENABLE: next_rdata[7:0] = irq_en;
                  tx_ctl_pkg::IDX_LINE_STAT:  next_rdata[0]   = monitor_short;
                  default:                    next_rdata      = 32'h0000_0000;
               endcase
            end
         end
         R_DATA: begin
            if (s_axi_rready) begin
               next_rd_state = R_IDLE;
            end
         end
         default: next_rd_state = R_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_state <= W_IDLE;
         bresp    <= tx_ctl_pkg::RESP_OKAY;
         rd_state <= R_IDLE;
         rdata    <= 32'h0000_0000;
         rresp    <= tx_ctl_pkg::RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         bresp    <= next_bresp;
         rd_state <= next_rd_state;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
      end
   end

   // register writes, sticky interrupts and the line monitor
   always_comb begin
      logic we;
      we                 = wr_fire && s_axi_wstrb[0];
      next_line_ctl      = line_ctl;
      next_sync_edge     = sync_edge;
      next_idle_code     = idle_code;
      next_dl_reg        = dl_reg;
      next_cc_reg        = cc_reg;
      next_ic_reg        = ic_reg;
      next_mode_ctl      = mode_ctl;
      next_irq_en        = irq_en;
      next_irq_stat      = irq_stat;
      next_monitor_short = monitor_short;
      if (we) begin
         unique case (wr_idx)
            tx_ctl_pkg::IDX_LINE_CTL:   next_line_ctl  = wbyte & tx_ctl_pkg::LC_MASK; // R04
            tx_ctl_pkg::IDX_SYNC_EDGE:  next_sync_edge = wbyte & tx_ctl_pkg::SE_MASK;
            tx_ctl_pkg::IDX_IDLE_CODE:  next_idle_code = wbyte;
            tx_ctl_pkg::IDX_DL_1:       next_dl_reg[0] = wbyte;
            tx_ctl_pkg::IDX_DL_2:       next_dl_reg[1] = wbyte;
            tx_ctl_pkg::IDX_DL_3:       next_dl_reg[2] = wbyte;
            tx_ctl_pkg::IDX_CC_1:       next_cc_reg[0] = wbyte;
            tx_ctl_pkg::IDX_CC_2:       next_cc_reg[1] = wbyte;
            tx_ctl_pkg::IDX_CC_3:       next_cc_reg[2] = wbyte;
            tx_ctl_pkg::IDX_IC_1:       next_ic_reg[0] = wbyte;
            tx_ctl_pkg::IDX_IC_2:       next_ic_reg[1] = wbyte;
            tx_ctl_pkg::IDX_IC_3:       next_ic_reg[2] = wbyte;
            tx_ctl_pkg::IDX_MODE_CTL:   next_mode_ctl  = wbyte & tx_ctl_pkg::MC_MASK;
            tx_ctl_pkg::IDX_IRQ_CLEAR:  next_irq_stat  = irq_stat & ~wbyte;
            tx_ctl_pkg::IDX_IRQ_ENABLE: next_irq_en    = wbyte & tx_ctl_pkg::IRQ_MASK;
            default:                    next_line_ctl  = line_ctl;
         endcase
      end
      // monitor status is frozen while the line is tristated
      if (!line_ctl[tx_ctl_pkg::LC_TRISTATE]) begin
         next_monitor_short = short_detect; // R01
      end
      // sets come after the clear so an event in the clear cycle survives
      if (mf_event) begin
         next_irq_stat[tx_ctl_pkg::IRQ_MF_BEGIN] = 1'b1; // R10
      end
      if (short_detect && !line_ctl[tx_ctl_pkg::LC_TRISTATE]) begin
         next_irq_stat[tx_ctl_pkg::IRQ_SHORT] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         line_ctl      <= tx_ctl_pkg::RST_LINE_CTL; // R01
         sync_edge     <= tx_ctl_pkg::RST_ZERO;
         idle_code     <= tx_ctl_pkg::RST_ZERO;
         dl_reg        <= '{default: tx_ctl_pkg::RST_ZERO};
         cc_reg        <= '{default: tx_ctl_pkg::RST_ZERO};
         ic_reg        <= '{default: tx_ctl_pkg::RST_ZERO};
         mode_ctl      <= tx_ctl_pkg::RST_ZERO;
         irq_en        <= tx_ctl_pkg::RST_ZERO;
         irq_stat      <= tx_ctl_pkg::RST_ZERO;
         monitor_short <= 1'b0;
      end else begin
         line_ctl      <= next_line_ctl;
         sync_edge     <= next_sync_edge;
         idle_code     <= next_idle_code;
         dl_reg        <= next_dl_reg;
         cc_reg        <= next_cc_reg;
         ic_reg        <= next_ic_reg;
         mode_ctl      <= next_mode_ctl;
         irq_en        <= next_irq_en;
         irq_stat      <= next_irq_stat;
         monitor_short <= next_monitor_short;
      end
   end

   // static controls; a short floats only the analog pair, as the monitor sees it
   assign irq                 = |(irq_stat & irq_en);
   assign digital_tx_oe       = !line_ctl[tx_ctl_pkg::LC_TRISTATE]; // R01
   assign analog_tx_out_oe    = !line_ctl[tx_ctl_pkg::LC_TRISTATE]
                                && !(monitor_short && !line_ctl[tx_ctl_pkg::LC_AUTO_DIS]); // R02
   assign pulse_source_select = line_ctl[tx_ctl_pkg::LC_PULSE_SRC]; // R03
   assign fourth_level_hi     = line_ctl[3:0]; // R04
   assign rx_sync_opposite    = sync_edge[tx_ctl_pkg::SE_ENABLE] && sync_edge[tx_ctl_pkg::SE_RX]; // R05 R06
   assign tx_sync_opposite    = sync_edge[tx_ctl_pkg::SE_ENABLE] && sync_edge[tx_ctl_pkg::SE_TX]; // R05 R07

   // slot content: idle and loop-back win, then robbing and zero suppression
   always_comb begin
      slot_byte = slot_in.data;
      if (slot_flag(ic_vec, slot_in.index)
          || (slot_in.looped && mode_ctl[tx_ctl_pkg::MC_LOOPBACK])) begin
         slot_byte = idle_code; // R08 R16
      end else if (!slot_flag(cc_vec, slot_in.index)) begin // R13 R14
         if (slot_in.rob_req && mode_ctl[tx_ctl_pkg::MC_ROBBING]) begin
            slot_byte = slot_in.rob_data;
         end
         if (slot_byte == 8'h00 && mode_ctl[tx_ctl_pkg::MC_ZCS]) begin
            slot_byte = tx_ctl_pkg::ZCS_STUFF;
         end
      end
   end

   // serialiser; a new slot reloads the shifter, msb leaves first
   always_comb begin
      next_shift    = shift;
      next_bit_cnt  = bit_cnt;
      next_line_bit = line_bit;
      if (slot_in.valid) begin
         next_shift    = slot_byte;
         next_bit_cnt  = 3'h0;
         next_line_bit = slot_byte[7]; // R09
      end else if (bit_tick && bit_cnt != tx_ctl_pkg::BITS_MAX) begin
         next_shift    = {shift[6:0], 1'b0};
         next_bit_cnt  = bit_cnt + 3'h1;
         next_line_bit = shift[6]; // R09
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shift    <= 8'h00;
         bit_cnt  <= tx_ctl_pkg::BITS_MAX;
         line_bit <= 1'b0;
      end else begin
         shift    <= next_shift;
         bit_cnt  <= next_bit_cnt;
         line_bit <= next_line_bit;
      end
   end

   // data link: shadow copy at multiframe start; unchanged registers repeat
   always_comb begin
      next_dl_shadow = dl_shadow;
      next_dl_ptr    = dl_ptr;
      next_dl_len    = dl_len;
      next_dl_send   = dl_send;
      next_dl_out    = '0;
      if (mf_event) begin
         next_dl_shadow = {dl_reg[2], dl_reg[1], dl_reg[0]}; // R10 R12
         next_dl_ptr    = 5'h00; // R11
         next_dl_send   = !mode_ctl[tx_ctl_pkg::MC_TRANSP]; // R10
         unique case (mode_ctl[6:tx_ctl_pkg::MC_FMT_LO])
            tx_ctl_pkg::FMT_F4:  next_dl_len = tx_ctl_pkg::DL_LEN_F4; // R11
            tx_ctl_pkg::FMT_F24: next_dl_len = tx_ctl_pkg::DL_LEN_F24;
            tx_ctl_pkg::FMT_F72: next_dl_len = tx_ctl_pkg::DL_LEN_F72;
            default:             next_dl_len = tx_ctl_pkg::DL_LEN_NONE;
         endcase
      end else if (dl_bit_req && dl_send && dl_ptr < dl_len) begin
         next_dl_out.valid     = 1'b1;
         next_dl_out.bit_value = dl_shadow[dl_ptr]; // R11
         next_dl_ptr           = dl_ptr + 5'h01;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dl_shadow <= 24'h000000;
         dl_ptr    <= 5'h00;
         dl_len    <= tx_ctl_pkg::DL_LEN_NONE;
         dl_send   <= 1'b0;
         dl_out    <= '0;
      end else begin
         dl_shadow <= next_dl_shadow;
         dl_ptr    <= next_dl_ptr;
         dl_len    <= next_dl_len;
         dl_send   <= next_dl_send;
         dl_out    <= next_dl_out;
      end
   end

   a_tristate_floats: assert property (@(posedge clk) disable iff (!resetn) // R01
      line_ctl[6] |-> !analog_tx_out_oe && !digital_tx_oe)
      else $error("line outputs driven while tristate set");
   a_monitor_frozen: assert property (@(posedge clk) disable iff (!resetn) // R01
      $past(line_ctl[6]) && line_ctl[6] |-> $stable(monitor_short))
      else $error("monitor status moved while frozen");
   a_auto_tristate: assert property (@(posedge clk) disable iff (!resetn) // R02
      monitor_short && !line_ctl[5] |-> !analog_tx_out_oe)
      else $error("short did not float analog outputs");
   a_bit7_zero: assert property (@(posedge clk) disable iff (!resetn) // R04
      line_ctl[7] == 1'b0)
      else $error("fixed-zero bit set");
   a_edge_gated: assert property (@(posedge clk) disable iff (!resetn) // R05
      !sync_edge[2] |-> !rx_sync_opposite && !tx_sync_opposite)
      else $error("edge choice active while disabled");
   a_idle_slot: assert property (@(posedge clk) disable iff (!resetn) // R16
      slot_in.valid && ic_vec[5'd23 - slot_in.index] |=> shift == $past(idle_code))
      else $error("idle slot not overwritten");
   a_clear_kept: assert property (@(posedge clk) disable iff (!resetn) // R14
      slot_in.valid && cc_vec[5'd23 - slot_in.index] && !ic_vec[5'd23 - slot_in.index]
      && !(slot_in.looped && mode_ctl[0]) |=> shift == $past(slot_in.data))
      else $error("clear channel altered");
   a_msb_first: assert property (@(posedge clk) disable iff (!resetn) // R09
      slot_in.valid |=> line_bit == shift[7])
      else $error("first bit is not the msb");
   a_mf_irq: assert property (@(posedge clk) disable iff (!resetn) // R10
      tx_multiframe_begin && mode_ctl[1] |=> irq_stat[0]
      && dl_shadow == {$past(dl_reg[2]), $past(dl_reg[1]), $past(dl_reg[0])})
      else $error("multiframe start missed");
   a_dl_count: assert property (@(posedge clk) disable iff (!resetn) // R11
      dl_out.valid |-> dl_ptr <= dl_len && dl_ptr != 5'h00)
      else $error("too many link bits");

endmodule : tx_channel_ctl

/* rtl/tx_ctl_pkg.sv */
package tx_ctl_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_LINE_CTL   = 8'h28;
   localparam logic [7:0] IDX_SYNC_EDGE  = 8'h2A;
   localparam logic [7:0] IDX_IDLE_CODE  = 8'h2B;
   localparam logic [7:0] IDX_DL_1       = 8'h2C;
   localparam logic [7:0] IDX_DL_2       = 8'h2D;
   localparam logic [7:0] IDX_DL_3       = 8'h2E;
   localparam logic [7:0] IDX_CC_1       = 8'h2F;
   localparam logic [7:0] IDX_CC_2       = 8'h30;
   localparam logic [7:0] IDX_CC_3       = 8'h31;
   localparam logic [7:0] IDX_IC_1       = 8'h32;
   localparam logic [7:0] IDX_IC_2       = 8'h33;
   localparam logic [7:0] IDX_IC_3       = 8'h34;
   localparam logic [7:0] IDX_MODE_CTL   = 8'h40;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h41;
   localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h42;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'h43;
   localparam logic [7:0] IDX_LINE_STAT  = 8'h44;

   // reset values
   localparam logic [7:0] RST_LINE_CTL = 8'h40;
   localparam logic [7:0] RST_ZERO     = 8'h00;

   // line control field positions and writable mask (bit 7 fixed zero)
   localparam int          LC_TRISTATE   = 6;
   localparam int          LC_AUTO_DIS   = 5;
   localparam int          LC_PULSE_SRC  = 4;
   localparam logic [7:0] LC_MASK       = 8'h7F;
   // sync edge control fields; bits 7:3 reserved
   localparam int          SE_ENABLE     = 2;
   localparam int          SE_RX         = 1;
   localparam int          SE_TX         = 0;
   localparam logic [7:0] SE_MASK       = 8'h07;
   // mode control fields
   localparam int          MC_LOOPBACK   = 0;
   localparam int          MC_DL_ACCESS  = 1;
   localparam int          MC_TRANSP     = 2;
   localparam int          MC_ROBBING    = 3;
   localparam int          MC_ZCS        = 4;
   localparam int          MC_FMT_LO     = 5;
   localparam logic [7:0] MC_MASK       = 8'h7F;
   // interrupt status bits
   localparam int          IRQ_MF_BEGIN  = 0;
   localparam int          IRQ_SHORT     = 1;
   localparam logic [7:0] IRQ_MASK      = 8'h03;

   // frame formats and the count of data-link bits each sends
   localparam logic [1:0] FMT_F4  = 2'h0;
   localparam logic [1:0] FMT_F24 = 2'h1;
   localparam logic [1:0] FMT_F72 = 2'h2;
   localparam logic [4:0] DL_LEN_F4  = 5'h02;
   localparam logic [4:0] DL_LEN_F24 = 5'h0C;
   localparam logic [4:0] DL_LEN_F72 = 5'h18;
   localparam logic [4:0] DL_LEN_NONE = 5'h00;

   localparam logic [4:0] LAST_SLOT   = 5'h17;
   localparam logic [7:0] ZCS_STUFF   = 8'h02;
   localparam logic [2:0] BITS_MAX    = 3'h7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one outgoing timeslot offered by the framer
   typedef struct packed {
      logic       valid;
      logic [4:0] index;    // 0 is timeslot 1
      logic [7:0] data;
      logic       rob_req;  // framer wants signalling bits in this slot
      logic [7:0] rob_data; // slot content with robbed bits inserted
      logic       looped;   // slot carries a looped channel
   } slot_in_s;

   // one data-link bit handed to the framer
   typedef struct packed {
      logic valid;
      logic bit_value;
   } dl_out_s;

endpackage : tx_ctl_pkg

/* test/framer_model.sv */
// framer side of the transmit path: offers slots, ticks bits, asks for link bits
module framer_model (
   input  wire logic                clk,
   input  wire logic                line_bit,
   input  wire tx_ctl_pkg::dl_out_s dl_out,
   output tx_ctl_pkg::slot_in_s     slot_in,
   output logic                     bit_tick,
   output logic                     tx_multiframe_begin,
   output logic                     dl_bit_req,
   output logic                     short_detect
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      slot_in = '0;
      {bit_tick, tx_multiframe_begin, dl_bit_req, short_detect} = 4'h0;
   end
   // fields are inverted once taken so a stale slot can never look right
   task send_slot(input logic [22:0] f, output logic [7:0] got);
      @(posedge clk);
      slot_in <= {1'b1, f};
      @(posedge clk);
      slot_in <= {1'b0, ~f};
      @(negedge clk);
      got[7] = line_bit;
      for (int k = 6; k >= 0; k--) begin
         @(posedge clk);
         bit_tick <= 1'b1;
         @(posedge clk);
         bit_tick <= 1'b0;
         @(negedge clk);
         got[k] = line_bit;
      end
   endtask : send_slot
   task pulse_mf();
      @(posedge clk);
      tx_multiframe_begin <= 1'b1;
      @(posedge clk);
      tx_multiframe_begin <= 1'b0;
   endtask : pulse_mf
   // answer is sampled in the one cycle that it stands
   task req_bit(output logic [1:0] got);
      @(posedge clk);
      dl_bit_req <= 1'b1;
      @(posedge clk);
      dl_bit_req <= 1'b0;
      @(negedge clk);
      got = dl_out;
   endtask : req_bit
endmodule : framer_model

/* test/t1_transmit_channel_control_bench.sv */
module t1_transmit_channel_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, fourth_level_hi;
   logic [1:0]  s_axi_bresp, s_axi_rresp, dl_got;
   logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, bit_tick, dl_bit_req, tx_multiframe_begin, short_detect;
   logic        line_bit, analog_tx_out_oe, digital_tx_oe, irq, pulse_source_select;
   logic        rx_sync_opposite, tx_sync_opposite;
   logic [7:0]  got;
   logic [33:0] rdw;
   tx_ctl_pkg::slot_in_s slot_in;
   tx_ctl_pkg::dl_out_s  dl_out;
   int          fail_count = 0;
   int          cmp_count = 0;
   // register rows: index, byte written, byte read back; 3F is unmapped
   logic [23:0] regs [7] = '{24'h28FF7F, 24'h2AFF07, 24'h2BA5A5, 24'h2E5A5A,
                             24'h318181, 24'h343C3C, 24'h3FFF00};
   // slot rows: index, data, rob request, robbed byte, looped, byte on the line
   logic [30:0] slots [6] = '{{5'h12, 8'h00, 1'b0, 8'h00, 1'b0, 8'hA5},
      {5'h11, 8'h00, 1'b0, 8'h00, 1'b0, 8'h02},
      {5'h11, 8'h96, 1'b0, 8'h00, 1'b0, 8'h96}, {5'h10, 8'h11, 1'b1, 8'h3C, 1'b0, 8'h11},
      {5'h16, 8'h11, 1'b1, 8'h3C, 1'b0, 8'h3C}, {5'h16, 8'h11, 1'b0, 8'h00, 1'b1, 8'hA5}};
   tx_channel_ctl dut_u (.*);
   framer_model framer_u (.*);
   always #5 clk = ~clk;
   task chk(input logic [33:0] g, input logic [33:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // write address and data go out together and are released when taken
   task wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= {2'h0, i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do @(negedge clk); while (!(s_axi_awready && s_axi_wready));
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      do @(negedge clk); while (!s_axi_bvalid);
      @(posedge clk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] i);
      @(posedge clk);
      s_axi_araddr <= {2'h0, i, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (!s_axi_rvalid);
      rdw = {s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      s_axi_rready <= 1'b0;
   endtask : rd
   task stop_test();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // a hung handshake wait ends here; the whole run needs about 230 cycles
   initial begin
      #200000;
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      stop_test();
   end
   initial begin
      {clk, resetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h28);
      chk(rdw, 34'h40);
      chk({analog_tx_out_oe, digital_tx_oe}, 2'h0);
      foreach (regs[i]) begin
         wr(regs[i][23:16], regs[i][15:8]);
         rd(regs[i][23:16]);
         chk(rdw, {((regs[i][23:16] == 8'h3F) ? 2'h2 : 2'h0), 24'h0, regs[i][7:0]});
      end
      chk({pulse_source_select, fourth_level_hi}, 5'h1F);
      chk({rx_sync_opposite, tx_sync_opposite}, 2'h3);
      wr(8'h2A, 8'h03);
      chk({rx_sync_opposite, tx_sync_opposite}, 2'h0);
      $display("register test done");
      wr(8'h40, 8'h19);
      foreach (slots[i]) begin
         framer_u.send_slot(slots[i][30:8], got);
         chk(got, slots[i][7:0]);
      end
      $display("slot test done");
      wr(8'h28, 8'h00);
      chk({analog_tx_out_oe, digital_tx_oe}, 2'h3);
      framer_u.short_detect <= 1'b1;
      repeat (2) @(negedge clk);
      chk(analog_tx_out_oe, 1'b0);
      wr(8'h28, 8'h20);
      chk(analog_tx_out_oe, 1'b1);
      framer_u.short_detect <= 1'b0;
      $display("line test done");
      wr(8'h2C, 8'h01);
      wr(8'h40, 8'h02);
      wr(8'h43, 8'h01);
      framer_u.pulse_mf();
      repeat (2) @(negedge clk);
      chk(irq, 1'b1);
      for (int k = 0; k < 3; k++) begin
         framer_u.req_bit(dl_got);
         chk(dl_got, (k == 0) ? 2'h3 : ((k == 1) ? 2'h2 : 2'h0));
      end
      wr(8'h42, 8'h01);
      chk(irq, 1'b0);
      framer_u.pulse_mf();
      framer_u.req_bit(dl_got);
      chk(dl_got, 2'h3);
      wr(8'h2D, 8'hFF);
      wr(8'h40, 8'h22);
      framer_u.pulse_mf();
      for (int k = 0; k < 13; k++) begin
         framer_u.req_bit(dl_got);
         chk(dl_got, (k == 0) ? 2'h3 : ((k < 8) ? 2'h2 : ((k < 12) ? 2'h3 : 2'h0)));
      end
      $display("data link test done");
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      rd(8'h28);
      chk(rdw, 34'h40);
      chk({analog_tx_out_oe, digital_tx_oe, irq}, 3'h0);
      $display("reset test done");
      stop_test();
   end
endmodule : t1_transmit_channel_control_bench
